// *** src/tic_top.v ***
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "tic_regs.vh"
module tic_top #(
  parameter NUM_EXT = 5
) (
  input  wire        SYS_CLK_IN,           // System clock, 10 MHz
  input  wire        ARST_N_IN,            // Async reset, active low
  input  wire        PSEL_IN,              // APB select
  input  wire        PENABLE_IN,           // APB access phase
  input  wire        PWRITE_IN,            // APB direction, 1 = write
  input  wire [11:0] PADDR_IN,             // APB byte address
  input  wire [31:0] PWDATA_IN,            // APB write data
  input  wire [3:0]  PSTRB_IN,             // APB byte strobes
  output wire [31:0] PRDATA_OUT,           // APB read data
  output wire        PREADY_OUT,           // APB ready
  output wire        PSLVERR_OUT,          // APB error, unmapped address
  input  wire        ACC_A_OVF_IN,         // Accumulator A overflow pulse
  input  wire        ACC_B_OVF_IN,         // Accumulator B overflow pulse
  input  wire        ACC_A_CAT_IN,         // Accumulator A catastrophic pulse
  input  wire        ACC_B_CAT_IN,         // Accumulator B catastrophic pulse
  input  wire        SHIFT_ERR_IN,         // Invalid accumulator shift pulse
  input  wire        DIV_ZERO_IN,          // Divide by zero pulse
  input  wire        DMA_ERR_IN,           // DMA controller error pulse
  input  wire        ADDR_ERR_IN,          // Address error pulse
  input  wire        STACK_ERR_IN,         // Stack error pulse
  input  wire        OSC_FAIL_IN,          // Oscillator failure pulse
  input  wire        TIMED_IRQ_DISABLE_ACTIVE_ACTIVE_IN,       // Core timed disable running
  input  wire [14:1] PERIPH_REQ_IN,        // Peripheral request pulses
  input  wire [4:0]  EXT_IRQ_IN,           // External interrupt pins
  output reg         MATH_TRAP_OUT,        // Math trap pulse
  output reg         DMA_TRAP_OUT,         // DMA trap pulse
  output reg         ADDR_TRAP_OUT,        // Address trap pulse
  output reg         STACK_TRAP_OUT,       // Stack trap pulse
  output reg         OSC_TRAP_OUT,         // Oscillator trap pulse
  output reg  [4:0]  EXT_EDGE_OUT,         // Qualified external edge pulses
  output wire        NEST_DISABLE_OUT,     // Nesting prevented
  output wire        ALT_TABLE_OUT,        // Alternate vector table in use
  output wire        PRIO_LOCK_OUT,        // CPU low priority bits read-only
  output wire [15:0] FLAGS0_OUT            // Interrupt flags zero
);

  reg  [15:0] ctl1_q;
  reg  [15:0] ctl1_d;
  reg  [15:0] ctl2_q;
  reg  [15:0] ctl2_d;
  reg  [15:0] flags0_q;
  reg  [15:0] flags0_d;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg  [4:0]  sync3_q;
  reg  [4:0]  lvl_q;
  reg  [4:0]  lvl_d;
  reg  [4:0]  edge_d;
  reg  [15:0] trap_set;
  reg  [15:0] wmask;
  wire        setup_ph;
  wire        wr_acc;
  wire        hit_ctl1;
  wire        hit_ctl2;
  wire        hit_flg0;
  wire        mapped;
  wire        ova_trap;
  wire        ovb_trap;
  wire        cova_trap;
  wire        covb_trap;
  wire        math_trap;

  // Merge a bus write into a register under byte strobes and a write mask
  function [15:0] merge_wr;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0]  strb;
    input [15:0] msk;
    reg   [15:0] lane;
    begin
      lane     = {{8{strb[1]}}, {8{strb[0]}}} & msk;
      merge_wr = (old & ~lane) | (wdat & lane);
    end
  endfunction

  assign setup_ph  = PSEL_IN & ~PENABLE_IN;
  assign wr_acc    = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign hit_ctl1  = (PADDR_IN == `TIC_OFF_CTL1);
  assign hit_ctl2  = (PADDR_IN == `TIC_OFF_CTL2);
  assign hit_flg0  = (PADDR_IN == `TIC_OFF_FLAGS0);
  assign mapped    = hit_ctl1 | hit_ctl2 | hit_flg0;

  // Zero wait state slave; read data is latched during setup
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign PRDATA_OUT  = prdata_q;

  // Overflow causes only trap while their enable is set
  assign ova_trap  = ACC_A_OVF_IN & ctl1_q[`TIC_CTL1_ACC_A_OVERFLOW_TRAP_EN];
  assign ovb_trap  = ACC_B_OVF_IN & ctl1_q[`TIC_CTL1_ACC_B_OVERFLOW_TRAP_EN];
  assign cova_trap = ACC_A_CAT_IN & ctl1_q[`TIC_CTL1_CATASTROPHIC_TRAP_EN];
  assign covb_trap = ACC_B_CAT_IN & ctl1_q[`TIC_CTL1_CATASTROPHIC_TRAP_EN];
  assign math_trap = ova_trap | ovb_trap | cova_trap | covb_trap
                     | SHIFT_ERR_IN | DIV_ZERO_IN;

  always @*
  begin
    trap_set                  = 16'h0000;
    trap_set[`TIC_CTL1_OVA]   = ova_trap;
    trap_set[`TIC_CTL1_OVB]   = ovb_trap;
    trap_set[`TIC_CTL1_COVA]  = cova_trap;
    trap_set[`TIC_CTL1_COVB]  = covb_trap;
    trap_set[`TIC_CTL1_SHIFT] = SHIFT_ERR_IN;
    trap_set[`TIC_CTL1_DIV0]  = DIV_ZERO_IN;
    trap_set[`TIC_CTL1_DMA]   = DMA_ERR_IN;
    trap_set[`TIC_CTL1_MATH]  = math_trap;
    trap_set[`TIC_CTL1_ADDR]  = ADDR_ERR_IN;
    trap_set[`TIC_CTL1_STACK] = STACK_ERR_IN;
    trap_set[`TIC_CTL1_OSC]   = OSC_FAIL_IN;
  end

  // Pins pass three flops; a change counts once stages two and three agree
  always @*
  begin
    lvl_d  = lvl_q;
    edge_d = 5'h00;
    wmask  = `TIC_CTL1_WMASK;
    lvl_d  = (sync2_q == sync3_q) ? sync3_q : lvl_q;
    // Falling edge when select is 1, rising edge when 0
    edge_d = (lvl_d ^ lvl_q) & (lvl_q ~^ ctl2_q[4:0]);
  end

  always @*
  begin
    ctl1_d   = ctl1_q;
    ctl2_d   = ctl2_q;
    flags0_d = flags0_q;
    if (wr_acc && hit_ctl1)
    begin
      ctl1_d = merge_wr(ctl1_q, PWDATA_IN[15:0], PSTRB_IN[1:0], wmask);
    end
    if (wr_acc && hit_ctl2)
    begin
      // Timed disable bit is not stored; it is read live from the core
      ctl2_d = merge_wr(ctl2_q, PWDATA_IN[15:0], PSTRB_IN[1:0],
                        `TIC_CTL2_WMASK);
    end
    if (wr_acc && hit_flg0)
    begin
      flags0_d = merge_wr(flags0_q, PWDATA_IN[15:0], PSTRB_IN[1:0],
                          `TIC_FLAGS0_MASK);
    end
    // Hardware set is applied last so it wins over a same-cycle clear
    ctl1_d   = ctl1_d | trap_set;
    flags0_d = flags0_d | ({PERIPH_REQ_IN, edge_d[0]} & `TIC_FLAGS0_MASK);
    ctl1_d[0]   = 1'b0;
    flags0_d[15] = 1'b0;
  end

  always @*
  begin
    prdata_d = 32'h0000_0000;
    if (hit_ctl1)
    begin
      prdata_d[15:0] = ctl1_q;
    end
    else if (hit_ctl2)
    begin
      prdata_d[15:0] = ctl2_q;
      prdata_d[`TIC_CTL2_TIMED_IRQ_DISABLE_ACTIVE] = TIMED_IRQ_DISABLE_ACTIVE_ACTIVE_IN;
    end
    else if (hit_flg0)
    begin
      prdata_d[15:0] = flags0_q;
    end
  end

  always @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      ctl1_q         <= `TIC_CTL1_RST;
      ctl2_q         <= `TIC_CTL2_RST;
      flags0_q       <= `TIC_FLAGS0_RST;
      prdata_q       <= 32'h0000_0000;
      sync1_q        <= 5'h00;
      sync2_q        <= 5'h00;
      sync3_q        <= 5'h00;
      lvl_q          <= 5'h00;
      EXT_EDGE_OUT   <= 5'h00;
      MATH_TRAP_OUT  <= 1'b0;
      DMA_TRAP_OUT   <= 1'b0;
      ADDR_TRAP_OUT  <= 1'b0;
      STACK_TRAP_OUT <= 1'b0;
      OSC_TRAP_OUT   <= 1'b0;
    end
    else
    begin
      ctl1_q         <= ctl1_d;
      ctl2_q         <= ctl2_d;
      flags0_q       <= flags0_d;
      if (setup_ph && !PWRITE_IN)
      begin
        prdata_q <= prdata_d;
      end
      sync1_q        <= EXT_IRQ_IN;
      sync2_q        <= sync1_q;
      sync3_q        <= sync2_q;
      lvl_q          <= lvl_d;
      EXT_EDGE_OUT   <= edge_d;
      MATH_TRAP_OUT  <= math_trap;
      DMA_TRAP_OUT   <= DMA_ERR_IN;
      ADDR_TRAP_OUT  <= ADDR_ERR_IN;
      STACK_TRAP_OUT <= STACK_ERR_IN;
      OSC_TRAP_OUT   <= OSC_FAIL_IN;
    end
  end

  assign NEST_DISABLE_OUT = ctl1_q[`TIC_CTL1_NSTD];
  assign ALT_TABLE_OUT    = ctl2_q[`TIC_CTL2_ALT];
  // Core must block writes to its low priority bits while this is high
  assign PRIO_LOCK_OUT    = ctl1_q[`TIC_CTL1_NSTD];
  assign FLAGS0_OUT       = flags0_q;

endmodule // tic_top

// *** shared/tic_regs.vh ***
// Behaviour
// - Control one bit 15 disables interrupt nesting when set.
// - Accumulator A or B overflow trap sets flag bit 14 or 13.
// - Catastrophic overflow trap of A or B sets flag bit 12 or 11.
// - Overflow traps of A and B are enabled by bits 10 and 9.
// - Bit 8 enables catastrophic overflow traps for both accumulators.
// - Invalid accumulator shift math trap sets status bit 7.
// - Divide by zero math trap sets status bit 6.
// - DMA controller error trap sets status bit 5.
// - Any math error trap sets status bit 4.
// - Address error trap sets status bit 3.
// - Stack error trap sets status bit 2.
// - Oscillator failure trap sets bit 1; bit 0 reads zero.
// - Control two bit 15 selects the alternate vector table.
// - Control two bit 14 is read-only, high while timed disable runs.
// - Bits 4..0 pick falling (1) or rising (0) edge per external input.
// - Interrupt flag reads 1 after a request; software may write it.
// - Flag bits 14..8 map DMA1, converter1, serial tx/rx, SPI, SPI fault, timer3.
// - Flag bits 7..0 map timer2, compare2, capture2, DMA0, timer1, compare1, capture1, ext0.
// - Flags are set by sources and cleared only by software write.
// - Nesting disabled makes the CPU low priority bits read-only.
`ifndef TIC_REGS_VH
`define TIC_REGS_VH
`define TIC_OFF_CTL1      12'h000
`define TIC_OFF_CTL2      12'h004
`define TIC_OFF_FLAGS0    12'h008
`define TIC_CTL1_RST      16'h0000
`define TIC_CTL2_RST      16'h0000
`define TIC_FLAGS0_RST    16'h0000
`define TIC_CTL1_NSTD     15
`define TIC_CTL1_OVA      14
`define TIC_CTL1_OVB      13
`define TIC_CTL1_COVA     12
`define TIC_CTL1_COVB     11
`define TIC_CTL1_ACC_A_OVERFLOW_TRAP_EN    10
`define TIC_CTL1_ACC_B_OVERFLOW_TRAP_EN    9
`define TIC_CTL1_CATASTROPHIC_TRAP_EN    8
`define TIC_CTL1_SHIFT    7
`define TIC_CTL1_DIV0     6
`define TIC_CTL1_DMA      5
`define TIC_CTL1_MATH     4
`define TIC_CTL1_ADDR     3
`define TIC_CTL1_STACK    2
`define TIC_CTL1_OSC      1
`define TIC_CTL1_WMASK    16'hfffe
`define TIC_CTL2_ALT      15
`define TIC_CTL2_TIMED_IRQ_DISABLE_ACTIVE     14
`define TIC_CTL2_WMASK    16'h801f
`define TIC_FLAGS0_MASK   16'h7fff
`define TIC_FLAG_EXT0     0
`endif

// *** sim/tic_asserts.sv ***
`timescale 1ns/10ps
`include "tic_regs.vh"
module tic_asserts (
  input wire        SYS_CLK_IN, ARST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire        PSLVERR_OUT, SHIFT_ERR_IN, DIV_ZERO_IN, DMA_ERR_IN, STACK_ERR_IN,
  input wire        OSC_FAIL_IN, MATH_TRAP_OUT, DMA_TRAP_OUT, STACK_TRAP_OUT, OSC_TRAP_OUT,
  input wire        NEST_DISABLE_OUT, PRIO_LOCK_OUT,
  input wire [14:1] PERIPH_REQ_IN,
  input wire [15:0] FLAGS0_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire flags_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == `TIC_OFF_FLAGS0;
  a_shift_math_trap: assert property (SHIFT_ERR_IN |=> MATH_TRAP_OUT)
    else $error("shift error gave no math trap");
  a_div_math_trap: assert property (DIV_ZERO_IN |=> MATH_TRAP_OUT)
    else $error("divide by zero gave no math trap");
  a_dma_trap: assert property (DMA_ERR_IN |=> DMA_TRAP_OUT)
    else $error("dma error gave no trap");
  a_stack_trap: assert property (STACK_ERR_IN |=> STACK_TRAP_OUT)
    else $error("stack error gave no trap");
  a_osc_trap: assert property (OSC_FAIL_IN |=> OSC_TRAP_OUT)
    else $error("oscillator failure gave no trap");
  a_request_sets_flag: assert property (|PERIPH_REQ_IN |=>
    (FLAGS0_OUT[14:1] & $past(PERIPH_REQ_IN)) == $past(PERIPH_REQ_IN))
    else $error("request did not set its flag");
  a_flag_sticky: assert property (!flags_wr |=>
    (FLAGS0_OUT & $past(FLAGS0_OUT)) == $past(FLAGS0_OUT))
    else $error("flag cleared without a write");
  a_flag_top_zero: assert property (FLAGS0_OUT[15] == 1'b0)
    else $error("flag bit 15 not zero");
  a_prio_lock_nest: assert property (PRIO_LOCK_OUT == NEST_DISABLE_OUT)
    else $error("priority lock differs from nesting disable");
  a_err_in_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("slave error outside access phase");
  c_div_zero: cover property (DIV_ZERO_IN ##1 MATH_TRAP_OUT);
  c_flags_write: cover property (flags_wr);
  c_nest_set: cover property (NEST_DISABLE_OUT);
endmodule // tic_asserts
bind tic_top tic_asserts u_chk (.SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PSLVERR_OUT(PSLVERR_OUT), .SHIFT_ERR_IN(SHIFT_ERR_IN), .DIV_ZERO_IN(DIV_ZERO_IN),
  .DMA_ERR_IN(DMA_ERR_IN), .STACK_ERR_IN(STACK_ERR_IN), .OSC_FAIL_IN(OSC_FAIL_IN),
  .MATH_TRAP_OUT(MATH_TRAP_OUT), .DMA_TRAP_OUT(DMA_TRAP_OUT),
  .STACK_TRAP_OUT(STACK_TRAP_OUT), .OSC_TRAP_OUT(OSC_TRAP_OUT),
  .NEST_DISABLE_OUT(NEST_DISABLE_OUT), .PRIO_LOCK_OUT(PRIO_LOCK_OUT),
  .PERIPH_REQ_IN(PERIPH_REQ_IN), .FLAGS0_OUT(FLAGS0_OUT));

// *** sim/tic_core_model.sv ***
`timescale 1ns/10ps
module tic_core_model (
  input  wire        clk_in,   // System clock
  output reg  [9:0]  trap_out, // A ovf, B ovf, A cat, B cat, shift, div0, dma, addr, stack, osc
  output reg  [14:1] req_out,  // Peripheral request pulses
  output reg  [4:0]  pin_out,  // External pins
  output reg         timed_irq_disable_active_out  // Timed disable running
);
  initial trap_out = 10'h000;
  initial req_out = 14'h0000;
  initial pin_out = 5'h00;
  initial timed_irq_disable_active_out = 1'b0;
  // One-cycle pulses, as the core raises them
  task fire(input [9:0] t, input [14:1] r);
    @(posedge clk_in);
    trap_out <= t;
    req_out <= r;
    @(posedge clk_in);
    trap_out <= 10'h000;
    req_out <= 14'h0000;
  endtask
  task pin_set(input [4:0] v);
    @(posedge clk_in);
    pin_out <= v;
  endtask
  task timed_irq_disable_active_set(input v);
    @(posedge clk_in);
    timed_irq_disable_active_out <= v;
  endtask
endmodule // tic_core_model

// *** sim/test_trap_and_interrupt_control.sv ***
`timescale 1ns/10ps
`include "tic_regs.vh"
module test_trap_and_interrupt_control;
  reg         clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwd = 32'h0, rd;
  wire [31:0] prdata;
  wire        pready, perr, nest, alt, lock, timed_irq_disable_active;
  wire [9:0]  trap;
  wire [14:1] req;
  wire [4:0]  pin;
  wire [15:0] flags;
  wire [4:0]  ext_edge;
  reg  [3:0]  pstrb = 4'hf;
  reg  [4:0]  seen;
  integer     mismatches = 0, check_count = 0, i;
  reg  [15:0] exp_tab [0:9] = '{16'h4710, 16'h2710, 16'h1710, 16'h0f10, 16'h0790,
                                16'h0750, 16'h0720, 16'h0708, 16'h0704, 16'h0702};
  initial forever #50 clk = ~clk;
  tic_core_model u_core (.clk_in(clk), .trap_out(trap), .req_out(req), .pin_out(pin),
    .timed_irq_disable_active_out(timed_irq_disable_active));
  tic_top u_dut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .ACC_A_OVF_IN(trap[9]), .ACC_B_OVF_IN(trap[8]),
    .ACC_A_CAT_IN(trap[7]), .ACC_B_CAT_IN(trap[6]), .SHIFT_ERR_IN(trap[5]),
    .DIV_ZERO_IN(trap[4]), .DMA_ERR_IN(trap[3]), .ADDR_ERR_IN(trap[2]), .STACK_ERR_IN(trap[1]),
    .OSC_FAIL_IN(trap[0]), .TIMED_IRQ_DISABLE_ACTIVE_ACTIVE_IN(timed_irq_disable_active), .PERIPH_REQ_IN(req), .EXT_IRQ_IN(pin),
    .MATH_TRAP_OUT(), .DMA_TRAP_OUT(), .ADDR_TRAP_OUT(), .STACK_TRAP_OUT(), .OSC_TRAP_OUT(),
    .EXT_EDGE_OUT(ext_edge), .NEST_DISABLE_OUT(nest), .ALT_TABLE_OUT(alt), .PRIO_LOCK_OUT(lock),
    .FLAGS0_OUT(flags));
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Gather edge pulses over eight cycles
  task wait8;
    seen = 5'h00;
    repeat (8)
    begin
      @(posedge clk);
      seen = seen | ext_edge;
    end
  endtask
  // Request held until pready is seen high
  task apb(input w, input [11:0] a, input [15:0] d);
    integer n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task t_reset;
    apb(0, `TIC_OFF_CTL1, 0); chk(rd, 0);
    apb(0, `TIC_OFF_CTL2, 0); chk(rd, 0);
    apb(0, `TIC_OFF_FLAGS0, 0); chk(rd, 0);
    chk({nest, alt, lock}, 0);
    apb(0, 12'h00c, 0); chk(err, 1);
    chk(rd, 0);
    $display("reset test done");
  endtask
  task t_ctl;
    apb(1, `TIC_OFF_CTL1, 16'hffff); apb(0, `TIC_OFF_CTL1, 0); chk(rd, 32'hfffe);
    chk({nest, lock}, 2'b11);
    @(posedge clk);
    pstrb <= 4'h2;
    apb(1, `TIC_OFF_CTL1, 0); apb(0, `TIC_OFF_CTL1, 0); chk(rd, 32'h00fe);
    pstrb <= 4'hf;
    apb(1, `TIC_OFF_CTL1, 0); chk({nest, lock}, 2'b00);
    apb(1, `TIC_OFF_CTL2, 16'hffff); apb(0, `TIC_OFF_CTL2, 0); chk(rd, 32'h801f);
    chk(alt, 1);
    u_core.timed_irq_disable_active_set(1); apb(0, `TIC_OFF_CTL2, 0); chk(rd, 32'hc01f);
    u_core.timed_irq_disable_active_set(0); apb(1, `TIC_OFF_CTL2, 0); apb(0, `TIC_OFF_CTL2, 0); chk(rd, 0);
    $display("control test done");
  endtask
  task t_traps;
    for (i = 0; i < 10; i++)
    begin
      apb(1, `TIC_OFF_CTL1, 16'h0700);
      u_core.fire(10'h200 >> i, 0);
      apb(0, `TIC_OFF_CTL1, 0); chk(rd, {16'h0, exp_tab[i]});
    end
    apb(1, `TIC_OFF_CTL1, 0); u_core.fire(10'h3c0, 0);
    apb(0, `TIC_OFF_CTL1, 0); chk(rd, 0);
    // Stack pulse lands on the clearing write edge
    fork
      apb(1, `TIC_OFF_CTL1, 16'h0700);
      begin @(posedge clk); u_core.fire(10'h002, 0); end
    join
    apb(0, `TIC_OFF_CTL1, 0); chk(rd, 32'h0704);
    $display("trap test done");
  endtask
  task t_flags;
    u_core.fire(0, 14'h3fff); apb(0, `TIC_OFF_FLAGS0, 0); chk(rd, 32'h7ffe);
    apb(1, `TIC_OFF_FLAGS0, 0); apb(0, `TIC_OFF_FLAGS0, 0); chk(rd, 0);
    apb(1, `TIC_OFF_FLAGS0, 16'hffff); apb(0, `TIC_OFF_FLAGS0, 0); chk(rd, 32'h7fff);
    apb(1, `TIC_OFF_FLAGS0, 0);
    u_core.pin_set(5'h1f); wait8; chk(flags, 16'h0001);
    chk(seen, 5'h1f);
    apb(1, `TIC_OFF_FLAGS0, 0); apb(1, `TIC_OFF_CTL2, 16'h001f);
    u_core.pin_set(0); wait8; chk(flags, 16'h0001);
    chk(seen, 5'h1f);
    apb(1, `TIC_OFF_FLAGS0, 0);
    u_core.pin_set(5'h1f); wait8; chk(flags, 0);
    chk(seen, 0);
    $display("flag test done");
  endtask
  task test_done;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    $display("Error at %0t: timeout", $time);
    test_done;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_ctl;
    t_traps;
    t_flags;
    test_done;
  end
endmodule // test_trap_and_interrupt_control
